// ==== hw/ubir_irda_filter.sv ====
`timescale 1ns/10ps
`default_nettype none
module ubir_irda_filter (
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic       rxd_pin,
   input  wire logic       encoded,
   input  wire logic [7:0] min_len,
   output logic            rx_level,
   output logic            pulse_ok
);
   // ------------------------------------------------------------
   // pin synchroniser, three stages
   // ------------------------------------------------------------
   logic       s1_r, s2_r, s3_r;  // first stage read by s2 only
   logic       lvl_r, lvl_nxt;    // debounced line level
   logic [8:0] run_r, run_nxt;    // length of current low pulse
   logic       ok_r, ok_nxt;      // accepted pulse strobe
   logic [8:0] need;              // pulse length required

   assign need = {1'b0, min_len} + ubir_pkg::PULSE_EXTRA;

   // next-state: level, pulse run and acceptance
   always_comb begin
      lvl_nxt = lvl_r;
      run_nxt = run_r;
      ok_nxt  = 1'b0;
      // change counts only once stages two and three agree
      if (s2_r == s3_r) begin
         lvl_nxt = s3_r;
      end
      if (encoded && !lvl_nxt) begin  // R13
         // saturate so a long low line never wraps back
         if (run_r != 9'h1ff) begin
            run_nxt = run_r + 9'h001;
         end
         ok_nxt = (run_nxt == need);  // R5
      end else begin
         run_nxt = 9'h000;  // short pulses simply die here
      end
   end

   // registers only
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_r  <= 1'b1;
         s2_r  <= 1'b1;
         s3_r  <= 1'b1;
         lvl_r <= 1'b1;
         run_r <= 9'h000;
         ok_r  <= 1'b0;
      end else begin
         s1_r  <= rxd_pin;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
         run_r <= run_nxt;
         ok_r  <= ok_nxt;
      end
   end

   // plain mode passes the level, encoded mode holds it high at all times
   assign rx_level = lvl_r | encoded;
   assign pulse_ok = ok_r;
endmodule
`default_nettype wire

// ==== hw/ubir_pkg.sv ====
package ubir_pkg;
   // ------------------------------
   // register byte addresses (index times four)
   // ------------------------------
   localparam logic [7:0] IDX_CTRL_A     = 8'h00;  // enable, sample rate
   localparam logic [7:0] IDX_CTRL_B     = 8'h04;  // char size, encoding
   localparam logic [7:0] IDX_CTRL_C     = 8'h08;  // empty control word
   localparam logic [7:0] IDX_BAUD       = 8'h0c;  // baud divisor
   localparam logic [7:0] IDX_PULSE      = 8'h0e;  // irda minimum pulse
   localparam logic [7:0] IDX_IEN_CLR    = 8'h14;  // enable clear view
   localparam logic [7:0] IDX_IEN_SET    = 8'h16;  // enable set view
   localparam logic [7:0] IDX_IRQ_STAT   = 8'h18;  // sticky event status
   localparam logic [9:0] ADDR_CTRL_A    = {IDX_CTRL_A, 2'b00};
   localparam logic [9:0] ADDR_CTRL_B    = {IDX_CTRL_B, 2'b00};
   localparam logic [9:0] ADDR_CTRL_C    = {IDX_CTRL_C, 2'b00};
   localparam logic [9:0] ADDR_BAUD      = {IDX_BAUD, 2'b00};
   localparam logic [9:0] ADDR_PULSE     = {IDX_PULSE, 2'b00};
   localparam logic [9:0] ADDR_IEN_CLR   = {IDX_IEN_CLR, 2'b00};
   localparam logic [9:0] ADDR_IEN_SET   = {IDX_IEN_SET, 2'b00};
   localparam logic [9:0] ADDR_IRQ_STAT  = {IDX_IRQ_STAT, 2'b00};
   // ------------------------------
   // field positions
   // ------------------------------
   localparam int ENABLE_BIT   = 1;   // port enable in control a
   localparam int RATE_SEL_BIT = 13;  // sample rate select bit zero
   localparam int ENCODE_BIT   = 10;  // line encoding select
   localparam int FRAC_MSB     = 15;  // fractional part top
   localparam int FRAC_LSB     = 13;  // fractional part bottom
   localparam int INT13_MSB    = 12;  // integer divisor top, split layout
   localparam logic [7:0] IRQ_VALID_MASK = 8'hbf;  // bit 6 always zero
   // ------------------------------
   // character size codes
   // ------------------------------
   localparam logic [2:0] CHSZ_8 = 3'h0;
   localparam logic [2:0] CHSZ_9 = 3'h1;
   localparam logic [2:0] CHSZ_5 = 3'h5;
   localparam logic [2:0] CHSZ_6 = 3'h6;
   localparam logic [2:0] CHSZ_7 = 3'h7;
   // ------------------------------
   // reset values and counts
   // ------------------------------
   localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
   localparam logic [15:0] RST_BAUD     = 16'h0000;
   localparam logic [7:0]  RST_PULSE    = 8'h00;
   localparam logic [7:0]  RST_IEN      = 8'h00;
   localparam logic [7:0]  RST_STAT     = 8'h00;
   localparam logic [8:0]  PULSE_EXTRA  = 9'h002;  // engine periods added
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ==== hw/ubir_top.sv ====
// Behaviour
// [R1] char size codes map to 8,9,5,6,7 bits
// [R2] char size applies at once, never busy
// [R3] sample bit clear: sixteen-bit divisor
// [R4] sample bit set: fraction 15:13, integer 12:0
// [R5] irda pulse needs length plus two periods
// [R6] protected registers ignore writes while enabled
// [R7] one written to clear view drops enable
// [R8] one written to set view raises enable
// [R9] zero bits leave enables untouched
// [R10] both views read one enable register
// [R11] enable bit positions fixed, bit 6 unused
// [R12] enables, baud and pulse reset to zero
// [R13] encoding select chooses plain or irda
// [R14] interrupt when flag and enable both set
`timescale 1ns/10ps
`default_nettype none
module ubir_top (
   input  wire logic        clock,
   input  wire logic        arst_n,
   // axi4-lite slave
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // serial engine side
   input  wire logic [7:0]  event_pulse,
   input  wire logic        rxd_pin,
   output logic             rx_level,
   output logic             irda_pulse_ok,
   output logic             port_enable,
   output logic             line_encoding_select,
   output logic [3:0]       char_bit_count,
   output logic             frac_mode,
   output logic [15:0]      baud_arith_div,
   output logic [12:0]      baud_int_div,
   output logic [2:0]       baud_fraction,
   output logic             irq
);
   // ------------------------------------------------------------
   // write channel state
   // ------------------------------------------------------------
   logic        aw_held_r, aw_held_nxt;  // address captured
   logic [9:0]  aw_addr_r, aw_addr_nxt;
   logic        w_held_r,  w_held_nxt;   // data captured
   logic [31:0] w_data_r,  w_data_nxt;
   logic [3:0]  w_strb_r,  w_strb_nxt;
   logic        bvalid_r,  bvalid_nxt;
   logic [1:0]  bresp_r,   bresp_nxt;
   logic        do_wr;                   // both halves present

   // ------------------------------------------------------------
   // read channel state
   // ------------------------------------------------------------
   logic        rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r,  rdata_nxt;
   logic [1:0]  rresp_r,  rresp_nxt;

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [31:0] ctrl_a_r, ctrl_a_nxt;    // enable, sample rate
   logic [31:0] ctrl_b_r, ctrl_b_nxt;    // char size, encoding
   logic [15:0] baud_r,   baud_nxt;      // divisor
   logic [7:0]  minpl_r,  minpl_nxt;     // irda minimum pulse
   logic [7:0]  ien_r,    ien_nxt;       // one shared enable set
   logic [7:0]  stat_r,   stat_nxt;      // sticky event flags
   logic [3:0]  chcnt_r,  chcnt_nxt;     // decoded bits per char
   logic [31:0] wmask;                   // byte lanes as bit mask
   logic        locked;                  // port running

   assign locked = ctrl_a_r[ubir_pkg::ENABLE_BIT];
   assign do_wr  = aw_held_r && w_held_r && !bvalid_r;

   // byte enables widened to a bit mask
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask[gi*8 +: 8] = {8{w_strb_r[gi]}};
      end
   endgenerate

   // ------------------------------------------------------------
   // write handshake
   // ------------------------------------------------------------
   // address and data may arrive in either order; each is held
   // until the other shows up, and the response follows both
   always_comb begin
      aw_held_nxt = aw_held_r;
      aw_addr_nxt = aw_addr_r;
      w_held_nxt  = w_held_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (do_wr) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         case (aw_addr_r)
            ubir_pkg::ADDR_CTRL_A, ubir_pkg::ADDR_CTRL_B,
            ubir_pkg::ADDR_CTRL_C, ubir_pkg::ADDR_BAUD,
            ubir_pkg::ADDR_PULSE, ubir_pkg::ADDR_IEN_CLR,
            ubir_pkg::ADDR_IEN_SET, ubir_pkg::ADDR_IRQ_STAT: begin
               bresp_nxt = ubir_pkg::RESP_OKAY;
            end
            default: begin
               bresp_nxt = ubir_pkg::RESP_SLVERR;  // unmapped
            end
         endcase
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 10'h000;
         w_held_r  <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'h0;
      end else begin
         aw_held_r <= aw_held_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_held_r  <= w_held_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
      end
   end

   // stall a new half until the previous response is gone
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;

   // ------------------------------------------------------------
   // register updates
   // ------------------------------------------------------------
   always_comb begin
      ctrl_a_nxt = ctrl_a_r;
      ctrl_b_nxt = ctrl_b_r;
      baud_nxt   = baud_r;
      minpl_nxt  = minpl_r;
      ien_nxt    = ien_r;
      // hardware events set, set beats a clear in the same cycle
      stat_nxt   = stat_r;
      if (do_wr) begin
         case (aw_addr_r)
            ubir_pkg::ADDR_CTRL_A: begin
               ctrl_a_nxt = (ctrl_a_r & ~wmask) | (w_data_r & wmask);
            end
            ubir_pkg::ADDR_CTRL_B: begin
               // no busy handshake: the new size is live next cycle
               if (!locked) begin
                  ctrl_b_nxt = (ctrl_b_r & ~wmask) | (w_data_r & wmask);  // R2
               end
            end
            ubir_pkg::ADDR_BAUD: begin
               if (!locked) begin  // R6
                  baud_nxt = (baud_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
               end
            end
            ubir_pkg::ADDR_PULSE: begin
               if (!locked) begin  // R6
                  minpl_nxt = (minpl_r & ~wmask[7:0]) | (w_data_r[7:0] & wmask[7:0]);
               end
            end
            ubir_pkg::ADDR_IEN_CLR: begin
               // zero bits and a dropped lane change nothing
               ien_nxt = ien_r & ~(w_data_r[7:0] & wmask[7:0]);  // R7 R9
            end
            ubir_pkg::ADDR_IEN_SET: begin
               ien_nxt = ien_r | (w_data_r[7:0] & wmask[7:0]);  // R8 R9
            end
            ubir_pkg::ADDR_IRQ_STAT: begin
               stat_nxt = stat_r & ~(w_data_r[7:0] & wmask[7:0]);
            end
            default: begin
               // control c and unmapped words store nothing
            end
         endcase
      end
      ien_nxt  = ien_nxt & ubir_pkg::IRQ_VALID_MASK;  // R11
      stat_nxt = (stat_nxt | event_pulse) & ubir_pkg::IRQ_VALID_MASK;
   end

   // bits per character, reserved codes give zero
   always_comb begin
      case (ctrl_b_nxt[2:0])  // R1
         ubir_pkg::CHSZ_8: chcnt_nxt = 4'h8;
         ubir_pkg::CHSZ_9: chcnt_nxt = 4'h9;
         ubir_pkg::CHSZ_5: chcnt_nxt = 4'h5;
         ubir_pkg::CHSZ_6: chcnt_nxt = 4'h6;
         ubir_pkg::CHSZ_7: chcnt_nxt = 4'h7;
         default:          chcnt_nxt = 4'h0;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_a_r <= ubir_pkg::RST_CTRL;
         ctrl_b_r <= ubir_pkg::RST_CTRL;
         baud_r   <= ubir_pkg::RST_BAUD;  // R12
         minpl_r  <= ubir_pkg::RST_PULSE;  // R12
         ien_r    <= ubir_pkg::RST_IEN;   // R12
         stat_r   <= ubir_pkg::RST_STAT;
         chcnt_r  <= 4'h8;
      end else begin
         ctrl_a_r <= ctrl_a_nxt;
         ctrl_b_r <= ctrl_b_nxt;
         baud_r   <= baud_nxt;
         minpl_r  <= minpl_nxt;
         ien_r    <= ien_nxt;
         stat_r   <= stat_nxt;
         chcnt_r  <= chcnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // one read at a time; the answer is registered one cycle later
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = ubir_pkg::RESP_OKAY;
         case (s_axi_araddr)
            ubir_pkg::ADDR_CTRL_A:   rdata_nxt = ctrl_a_r;
            ubir_pkg::ADDR_CTRL_B:   rdata_nxt = ctrl_b_r;
            ubir_pkg::ADDR_CTRL_C:   rdata_nxt = 32'h0000_0000;
            ubir_pkg::ADDR_BAUD:     rdata_nxt = {16'h0000, baud_r};
            ubir_pkg::ADDR_PULSE:    rdata_nxt = {24'h00_0000, minpl_r};
            ubir_pkg::ADDR_IEN_CLR,
            ubir_pkg::ADDR_IEN_SET:  rdata_nxt = {24'h00_0000, ien_r};  // R10
            ubir_pkg::ADDR_IRQ_STAT: rdata_nxt = {24'h00_0000, stat_r};
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = ubir_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= 2'h0;
      end else begin
         rvalid_r <= rvalid_nxt;
         rdata_r  <= rdata_nxt;
         rresp_r  <= rresp_nxt;
      end
   end

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // ------------------------------------------------------------
   // configuration outputs
   // ------------------------------------------------------------
   assign port_enable          = locked;
   assign line_encoding_select = ctrl_b_r[ubir_pkg::ENCODE_BIT];  // R13
   assign char_bit_count       = chcnt_r;
   assign frac_mode            = ctrl_a_r[ubir_pkg::RATE_SEL_BIT];
   // the idle layout's outputs read zero so nothing mixes the two
   assign baud_arith_div = frac_mode ? 16'h0000 : baud_r;  // R3
   assign baud_int_div   = frac_mode ? baud_r[ubir_pkg::INT13_MSB:0] : 13'h0000;  // R4
   assign baud_fraction  = frac_mode ? baud_r[ubir_pkg::FRAC_MSB:ubir_pkg::FRAC_LSB]
                                     : 3'h0;  // R4

   // level interrupt: any flag whose enable is set
   assign irq = |(stat_r & ien_r);  // R14

   // ------------------------------------------------------------
   // irda receive filter
   // ------------------------------------------------------------
   ubir_irda_filter u_filter (
      .clock    (clock),
      .arst_n   (arst_n),
      .rxd_pin  (rxd_pin),
      .encoded  (line_encoding_select),
      .min_len  (minpl_r),
      .rx_level (rx_level),
      .pulse_ok (irda_pulse_ok)
   );
endmodule
`default_nettype wire

// ==== verif/tb_ubir_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_ubir_top;
   // ------------------------------
   // clock, reset, bus and engine signals
   // ------------------------------
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [7:0]  event_pulse = 8'h00, ien, m;
   logic        rxd_pin, rx_level, irda_pulse_ok, port_enable, line_encoding_select;
   logic        frac_mode, irq;
   logic [3:0]  char_bit_count;
   logic [15:0] baud_arith_div, b;
   logic [12:0] baud_int_div;
   logic [2:0]  baud_fraction;
   logic [31:0] d;
   int          fail_count = 0, check_count = 0, p, cnt;
   always #5 clock = ~clock;  // 100 MHz
   ubir_top uut (.*);
   ubir_remote rm (.clock, .rxd_pin);
   // ------------------------------
   // compare, verdict, expectations
   // ------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results;
      if (fail_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [3:0] nbits(input logic [2:0] c);
      case (c)
         3'h0: return 4'h8;
         3'h1: return 4'h9;
         3'h5: return 4'h5;
         3'h6: return 4'h6;
         3'h7: return 4'h7;
         default: return 4'h0;  // reserved codes give no size
      endcase
   endfunction
   // ------------------------------
   // bus master: starts after a rising edge, ends at a falling one
   // ------------------------------
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin  // only the watchdog ends a hang
         @(negedge clock);  // ready lines settle before the edge
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(negedge clock);
   endtask
   task automatic rdc(input logic [9:0] a, input logic [31:0] exp, input string nm);
      logic ta, tr;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge clock);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(negedge clock);
      chk(nm, d, exp);
   endtask
   // watchdog: the whole run needs a few hundred cycles
   initial begin
      #500000;
      fail_count++;
      results;
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      void'($urandom(84814));
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      @(negedge clock);
      chk("bits_rst", 32'(char_bit_count), 32'h8);
      chk("level_rst", 32'(rx_level), 32'h1);
      rdc(ubir_pkg::ADDR_BAUD, 32'h0, "baud_rst");
      rdc(ubir_pkg::ADDR_PULSE, 32'h0, "pulse_rst");
      rdc(ubir_pkg::ADDR_IEN_SET, 32'h0, "ien_rst");
      // unmapped place and the empty control word
      wr(10'h3fc, 32'h1);
      chk("wr_unmap", 32'(r), 32'(ubir_pkg::RESP_SLVERR));
      rdc(10'h3fc, 32'h0, "rd_unmap_data");
      chk("rd_unmap", 32'(r), 32'(ubir_pkg::RESP_SLVERR));
      wr(ubir_pkg::ADDR_CTRL_C, 32'hffff_ffff);
      rdc(ubir_pkg::ADDR_CTRL_C, 32'h0, "ctrl_c");
      // both divisor layouts
      b = 16'($urandom);
      wr(ubir_pkg::ADDR_BAUD, 32'(b));
      rdc(ubir_pkg::ADDR_BAUD, 32'(b), "baud_rb");
      chk("arith", 32'(baud_arith_div), 32'(b));
      wr(ubir_pkg::ADDR_CTRL_A, 32'h2000);
      chk("int13", 32'(baud_int_div), 32'(b[12:0]));
      chk("frac", 32'(baud_fraction), 32'(b[15:13]));
      // writes while enabled are dropped
      wr(ubir_pkg::ADDR_CTRL_A, 32'h2);
      chk("port_en", 32'(port_enable), 32'h1);
      wr(ubir_pkg::ADDR_BAUD, 32'(~b));
      wr(ubir_pkg::ADDR_PULSE, 32'h5a);
      wr(ubir_pkg::ADDR_CTRL_B, 32'h5);
      rdc(ubir_pkg::ADDR_BAUD, 32'(b), "baud_prot");
      rdc(ubir_pkg::ADDR_PULSE, 32'h0, "pulse_prot");
      chk("bits_prot", 32'(char_bit_count), 32'h8);
      wr(ubir_pkg::ADDR_CTRL_A, 32'h0);
      // every size code, effective at once
      for (int c = 0; c < 8; c++) begin
         wr(ubir_pkg::ADDR_CTRL_B, 32'(c));
         chk("bits", 32'(char_bit_count), 32'(nbits(3'(c))));
      end
      // random set and clear through both views
      ien = 8'h00;
      repeat (24) begin
         d = $urandom;
         wr(d[8] ? ubir_pkg::ADDR_IEN_SET : ubir_pkg::ADDR_IEN_CLR, 32'(d[7:0]));
         ien = (d[8] ? (ien | d[7:0]) : (ien & ~d[7:0])) & 8'hbf;
         rdc(ubir_pkg::ADDR_IEN_CLR, 32'(ien), "ien_clr");
         rdc(ubir_pkg::ADDR_IEN_SET, 32'(ien), "ien_set");
      end
      // each event: masked, unmasked, masked again, cleared
      wr(ubir_pkg::ADDR_IEN_CLR, 32'hff);
      wr(ubir_pkg::ADDR_IRQ_STAT, 32'hff);
      for (int i = 0; i < 8; i++) begin
         m = 8'h01 << i;
         @(posedge clock);
         event_pulse <= m;
         @(posedge clock);
         event_pulse <= 8'h00;
         @(negedge clock);
         chk("irq_mask", 32'(irq), 32'h0);
         wr(ubir_pkg::ADDR_IEN_SET, 32'(m));
         chk("irq_on", 32'(irq), 32'(i != 6));
         wr(ubir_pkg::ADDR_IEN_CLR, 32'(m));
         chk("irq_clr", 32'(irq), 32'h0);
         wr(ubir_pkg::ADDR_IEN_SET, 32'(m));
         wr(ubir_pkg::ADDR_IRQ_STAT, 32'(m));
         chk("irq_ack", 32'(irq), 32'h0);
         wr(ubir_pkg::ADDR_IEN_CLR, 32'(m));
      end
      // pulse filter at its boundary, then plain mode
      p = 1 + $urandom % 6;
      wr(ubir_pkg::ADDR_PULSE, 32'(p));
      wr(ubir_pkg::ADDR_CTRL_B, 32'h400);
      chk("encode", 32'(line_encoding_select), 32'h1);
      for (int k = 0; k < 3; k++) begin
         if (k == 2) wr(ubir_pkg::ADDR_CTRL_B, 32'h0);
         cnt = 0;
         @(posedge clock);
         fork
            rm.pulse(p + 1 + int'(k > 0));
            repeat (p + 14) begin
               @(negedge clock);
               cnt += int'(irda_pulse_ok);
            end
         join
         chk("pulses", 32'(cnt), 32'(k == 1));
      end
      results;
   end
endmodule
`default_nettype wire

// ==== verif/ubir_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module ubir_chk (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [7:0]  event_pulse,
   input wire logic        rx_level,
   input wire logic        irda_pulse_ok,
   input wire logic        line_encoding_select,
   input wire logic [3:0]  char_bit_count,
   input wire logic        frac_mode,
   input wire logic [15:0] baud_arith_div,
   input wire logic [12:0] baud_int_div,
   input wire logic [2:0]  baud_fraction,
   input wire logic        irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ------------------------------
   // steps of a write: both halves taken, then commit
   // ------------------------------
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_commit;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_write_latency: assert property (s_both_taken |=> s_commit)
      else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_ready_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   // ------------------------------
   // configuration outputs stay legal and move only when a write commits
   // ------------------------------
   a_char_legal: assert property (char_bit_count inside {4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9})
      else $error("char size out of range");
   a_char_on_write: assert property ($changed(char_bit_count) |-> $rose(s_axi_bvalid))
      else $error("char size moved off a write");
   a_baud_layout: assert property (frac_mode ? baud_arith_div == 16'h0000 : (baud_int_div == 13'h0000 && baud_fraction == 3'h0))
      else $error("baud layout mixed");
   a_baud_on_write: assert property ($changed({frac_mode, baud_arith_div, baud_int_div}) |-> $rose(s_axi_bvalid))
      else $error("baud moved off a write");
   // ------------------------------
   // receive filter and interrupt line
   // ------------------------------
   a_rx_forced: assert property (line_encoding_select [*3] |-> rx_level)
      else $error("plain level leaks in encoded mode");
   a_pulse_single: assert property (irda_pulse_ok |=> !irda_pulse_ok)
      else $error("pulse flag too long");
   a_pulse_encoded: assert property (irda_pulse_ok |-> line_encoding_select)
      else $error("pulse flag in plain mode");
   a_irq_cause: assert property ($rose(irq) |-> ($past(event_pulse) & 8'hbf) != 8'h00 || $rose(s_axi_bvalid))
      else $error("interrupt without cause");
   a_irq_drop: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
      else $error("interrupt dropped without write");
endmodule
bind ubir_top ubir_chk u_chk (.*);
`default_nettype wire

// ==== verif/ubir_remote.sv ====
`timescale 1ns/10ps
`default_nettype none
module ubir_remote (
   input  wire logic clock,
   output logic      rxd_pin
);
   // ------------------------------
   // far serial device: idle high, low pulses on demand
   // ------------------------------
   initial rxd_pin = 1'b1;  // line idles at the pull-up level
   // low pulse of n engine periods, driven just after edges
   task automatic pulse(input int n);
      rxd_pin <= 1'b0;
      repeat (n) @(posedge clock);
      rxd_pin <= 1'b1;
   endtask
endmodule
`default_nettype wire
